// file: ibm_frame_host.sv
// Partner model: remote management host that offers received management frames
`timescale 1ns/1ps
`default_nettype none
module ibm_frame_host (
   input  wire logic       clk,
   input  wire logic       frame_accept,
   output ibm_pkg::ibm_rx_t rx
);
   import ibm_pkg::*;

   // Idle at time zero so the filter sees no frame
   initial begin
      rx = '0;
   end

   // One frame per call; qualifiers flip afterwards so no stale match survives
   task automatic send(input logic da, input logic tag, output logic acc);
      @(negedge clk) rx <= '{1'b1, da, tag};
      #1 acc = frame_accept;
      @(negedge clk) rx <= '{1'b0, ~da, ~tag};
   endtask
endmodule
`default_nettype wire

// file: ibm_pkg.sv
// Package: offsets, field layouts and reset values of the in-band management registers
package ibm_pkg;
   localparam logic [11:0] CTRL_OFFSET      = 12'h104;
   localparam logic [11:0] DRIVE_OFFSET     = 12'h10d;
   localparam int          EN_BIT           = 31;
   localparam int          DA_CHECK_BIT     = 30;
   localparam int          SM_RESET_BIT     = 29;
   localparam int          PRIO_LSB         = 22;
   localparam int          PORT_LSB         = 16;
   localparam int          HS_LSB           = 4;
   localparam int          LS_LSB           = 0;
   localparam int          RSV7_BIT         = 7;
   localparam int          RSV3_BIT         = 3;
   localparam logic        DA_CHECK_RESET   = 1'b1;
   localparam logic [1:0]  PRIO_RESET       = 2'h1;
   localparam logic [2:0]  PORT_RESET       = 3'h2;
   localparam logic [15:0] ETYPE_RESET      = 16'h40fe;
   localparam logic [2:0]  HS_RESET         = 3'h6;
   localparam logic [2:0]  LS_RESET         = 3'h2;
   localparam logic [2:0]  PORT_MAX_CODE    = 3'h2;

   // Bus request from software or the in-band command engine
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [31:0] wdata;
   } ibm_req_t;

   // Status from the frame checker for one received management frame
   typedef struct packed {
      logic frame_valid;
      logic da_match;
      logic tag_match;
   } ibm_rx_t;

   typedef enum logic [1:0] {
      IBM_IDLE,
      IBM_RUN,
      IBM_INIT
   } ibm_state_t;
endpackage

// file: ibm_regs.sv
// In-band management control register bank with drive-strength register
`timescale 1ns/1ps
`default_nettype none
module ibm_regs (
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic              inband_enable_strap_pin,
   input  wire ibm_pkg::ibm_req_t req,
   output logic [31:0]            rdata,
   output logic                   rvalid,
   input  wire ibm_pkg::ibm_rx_t  rx,
   output logic                   frame_accept,
   output logic                   addr_mismatch_err,
   output logic                   in_band_access_on,
   output logic [1:0]             resp_queue,
   output logic [2:0]             mgmt_port_onehot,
   output logic [15:0]            mgmt_ethertype,
   output logic [2:0]             hs_drive,
   output logic [2:0]             ls_drive,
   output ibm_pkg::ibm_state_t    sm_state
);
   import ibm_pkg::*;

   logic [1:0]  rst_sync_reg;
   logic        rst_n;
   logic        strap_s1_reg, strap_s2_reg;
   logic [1:0]  strap_fill_reg;
   logic        strap_done_reg;
   logic        en_reg;
   logic        da_check_reg;
   logic        sm_reset_reg;
   logic [1:0]  prio_reg;
   logic [2:0]  port_reg;
   logic [15:0] etype_reg;
   logic [7:0]  drive_reg;
   logic        mismatch_reg;
   logic [31:0] rdata_next;
   logic        wr_ctrl, wr_drive;
   ibm_state_t  state_reg;

   // Reset release through two flops so every flop on rst_n leaves reset on the same edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // Strap pin synchroniser; the pin is asynchronous to clk. The fill chain marks
   // when the second stage holds a real pin sample rather than its reset value.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_s1_reg   <= 1'b0;
         strap_s2_reg   <= 1'b0;
         strap_fill_reg <= 2'h0;
      end else begin
         strap_s1_reg   <= inband_enable_strap_pin;
         strap_s2_reg   <= strap_s1_reg;
         strap_fill_reg <= {strap_fill_reg[0], 1'b1};
      end
   end

   assign wr_ctrl  = req.wr && (req.addr == CTRL_OFFSET);
   assign wr_drive = req.wr && (req.addr == DRIVE_OFFSET);

   // Enable bit: strap caught once after release, software may override later
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         en_reg         <= 1'b0;
         strap_done_reg <= 1'b0;
      end else if (wr_ctrl) begin
         en_reg         <= req.wdata[EN_BIT];
         strap_done_reg <= 1'b1;
      end else if (!strap_done_reg && strap_fill_reg[1]) begin
         // Only the second stage is read; capturing earlier would latch a reset zero
         en_reg         <= strap_s2_reg;
         strap_done_reg <= 1'b1;
      end
   end

   // Control fields; reserved positions are not stored at all
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         da_check_reg <= DA_CHECK_RESET;
         prio_reg     <= PRIO_RESET;
         port_reg     <= PORT_RESET;
         etype_reg    <= ETYPE_RESET;
      end else if (wr_ctrl) begin
         da_check_reg <= req.wdata[DA_CHECK_BIT];
         prio_reg     <= req.wdata[PRIO_LSB +: 2];
         port_reg     <= req.wdata[PORT_LSB +: 3];
         etype_reg    <= req.wdata[15:0];
      end
   end

   // Self-clearing reset request: set for one cycle per write of one
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sm_reset_reg <= 1'b0;
      end else begin
         sm_reset_reg <= wr_ctrl && req.wdata[SM_RESET_BIT];
      end
   end

   // Management state machine; the reset request wins over any frame activity
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= IBM_IDLE;
      end else begin
         unique case (state_reg)
            IBM_INIT: state_reg <= IBM_IDLE;
            IBM_IDLE: begin
               if (sm_reset_reg) state_reg <= IBM_INIT;
               else if (frame_accept) state_reg <= IBM_RUN;
            end
            IBM_RUN: begin
               if (sm_reset_reg) state_reg <= IBM_INIT;
               else state_reg <= IBM_IDLE;
            end
            default: state_reg <= IBM_IDLE;
         endcase
      end
   end
   assign sm_state = state_reg;

   // Drive strength register; reserved bits 7 and 3 are plain read/write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         drive_reg <= {1'b0, HS_RESET, 1'b0, LS_RESET};
      end else if (wr_drive) begin
         drive_reg <= req.wdata[7:0];
      end
   end

   // Frame filter: frames pass only with a valid port and enable set, then the address check applies
   assign frame_accept = rx.frame_valid && in_band_access_on && (port_reg <= PORT_MAX_CODE)
                         && (rx.da_match || !da_check_reg);

   // Mismatch flag; a set in the same cycle as a clear wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mismatch_reg <= 1'b0;
      end else if (rx.frame_valid && in_band_access_on && da_check_reg && !rx.da_match) begin
         mismatch_reg <= 1'b1;
      end else if (rx.frame_valid && rx.tag_match) begin
         mismatch_reg <= 1'b0;
      end
   end
   assign addr_mismatch_err = mismatch_reg;

   // Read mux; the self-clearing bit always reads back zero
   always_comb begin
      rdata_next = 32'h0;
      if (req.addr == CTRL_OFFSET) begin
         rdata_next[EN_BIT]          = en_reg;
         rdata_next[DA_CHECK_BIT]    = da_check_reg;
         rdata_next[PRIO_LSB +: 2]   = prio_reg;
         rdata_next[PORT_LSB +: 3]   = port_reg;
         rdata_next[15:0]            = etype_reg;
      end else if (req.addr == DRIVE_OFFSET) begin
         rdata_next[7:0] = drive_reg;
      end
   end

   // Registered read data, answered one cycle after the request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata  <= 32'h0;
         rvalid <= 1'b0;
      end else begin
         rvalid <= req.rd;
         if (req.rd) rdata <= rdata_next;
      end
   end

   assign in_band_access_on = en_reg;
   assign resp_queue        = prio_reg;
   assign mgmt_ethertype    = etype_reg;
   assign hs_drive          = drive_reg[HS_LSB +: 3];
   assign ls_drive          = drive_reg[LS_LSB +: 3];

   // One-hot port select; reserved codes give no port
   always_comb begin
      mgmt_port_onehot = 3'h0;
      if (port_reg <= PORT_MAX_CODE) mgmt_port_onehot[port_reg[1:0]] = 1'b1;
   end

   a_reset_self_clear: assert property (@(posedge clk) disable iff (!rst_n)
      sm_reset_reg |=> !sm_reset_reg || $past(wr_ctrl && req.wdata[SM_RESET_BIT]))
      else $error("reset bit did not self clear");

   sequence s_reset_req;
      wr_ctrl && req.wdata[SM_RESET_BIT];
   endsequence
   a_reset_to_init: assert property (@(posedge clk) disable iff (!rst_n)
      s_reset_req ##1 (state_reg != IBM_INIT) |=> state_reg == IBM_INIT)
      else $error("state machine not reinitialised");

   a_da_drop: assert property (@(posedge clk) disable iff (!rst_n)
      (da_check_reg && !rx.da_match) |-> !frame_accept)
      else $error("mismatched frame accepted");

   a_da_skip: assert property (@(posedge clk) disable iff (!rst_n)
      (rx.frame_valid && en_reg && !da_check_reg && port_reg <= PORT_MAX_CODE) |-> frame_accept)
      else $error("frame dropped with check off");

   a_mismatch_set: assert property (@(posedge clk) disable iff (!rst_n)
      (rx.frame_valid && en_reg && da_check_reg && !rx.da_match) |=> addr_mismatch_err)
      else $error("mismatch flag not set");

   a_ctrl_write: assert property (@(posedge clk) disable iff (!rst_n)
      wr_ctrl |=> (mgmt_ethertype == $past(req.wdata[15:0]))
                  && (resp_queue == $past(req.wdata[23:22])) && (en_reg == $past(req.wdata[31])))
      else $error("control write not stored");

   a_reserved_port: assert property (@(posedge clk) disable iff (!rst_n)
      (port_reg > PORT_MAX_CODE) |-> (mgmt_port_onehot == 3'h0) && !frame_accept)
      else $error("reserved port code active");

   a_drive_write: assert property (@(posedge clk) disable iff (!rst_n)
      wr_drive |=> (hs_drive == $past(req.wdata[6:4])) && (ls_drive == $past(req.wdata[2:0])))
      else $error("drive write not stored");

   a_read_zero: assert property (@(posedge clk) disable iff (!rst_n)
      (req.rd && req.addr == CTRL_OFFSET) |=> (rdata[29:24] == 6'h0) && (rdata[21:19] == 3'h0))
      else $error("reserved bits read nonzero");
endmodule
`default_nettype wire

// file: inband_mgmt_control_regs_tb.sv
// Self-checking bench for the in-band management control registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module inband_mgmt_control_regs_tb;
   import ibm_pkg::*;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        strap = 1'b1;
   ibm_req_t    req = '0;
   ibm_rx_t     rx;
   logic [31:0] rdata;
   logic        rvalid, frame_accept, addr_mismatch_err, in_band_access_on;
   logic [1:0]  resp_queue;
   logic [2:0]  mgmt_port_onehot, hs_drive, ls_drive;
   logic [15:0] mgmt_ethertype;
   ibm_state_t  sm_state;
   int          num_errors = 0;
   int          cmp_count = 0;
   int          i;
   logic [31:0] ctrl_m, drv_m, got;
   logic        err_m, acc;
   // Frame table: control value, address match and tag match per entry
   logic [31:0] fc [6] = '{32'hc04240fe, 32'hc04240fe, 32'h804040fe,
                           32'h404140fe, 32'hc04540fe, 32'hc04140fe};
   logic [5:0]  fd = 6'b011010;
   logic [5:0]  ft = 6'b100010;

   always #12.5 clk = ~clk;

   ibm_regs dut (.clk(clk), .reset_n(reset_n), .inband_enable_strap_pin(strap), .req(req),
      .rdata(rdata), .rvalid(rvalid), .rx(rx), .frame_accept(frame_accept),
      .addr_mismatch_err(addr_mismatch_err), .in_band_access_on(in_band_access_on),
      .resp_queue(resp_queue), .mgmt_port_onehot(mgmt_port_onehot),
      .mgmt_ethertype(mgmt_ethertype), .hs_drive(hs_drive), .ls_drive(ls_drive),
      .sm_state(sm_state));

   ibm_frame_host host (.clk(clk), .frame_accept(frame_accept), .rx(rx));

   task automatic wrap_up;
      if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Reset with a chosen strap level; waits past strap capture before any use
   task automatic do_reset(input logic s);
      @(negedge clk) reset_n <= 1'b0;
      strap <= s;
      repeat (2) @(negedge clk);
      reset_n <= 1'b1;
      repeat (7) @(negedge clk);
      ctrl_m = {s, 1'b1, 6'h00, 2'h1, 3'h0, 3'h2, 16'h40fe};
      drv_m = 32'h62;
      err_m = 1'b0;
   endtask

   // Register write; the model keeps only what is writable
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(negedge clk) req <= '{1'b1, 1'b0, a, d};
      @(negedge clk) req.wr <= 1'b0;
      if (a == CTRL_OFFSET) ctrl_m = d & 32'hc0c7ffff;
      if (a == DRIVE_OFFSET) drv_m = {24'h0, d[7:0]};
   endtask

   // Register read; answer stands only in the cycle after the request
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      @(negedge clk) req <= '{1'b0, 1'b1, a, $urandom};
      @(negedge clk) req.rd <= 1'b0;
      `CHK(rvalid, 1'b1)
      `CHK(rdata, e)
   endtask

   task automatic chk_out;
      `CHK(in_band_access_on, ctrl_m[31])
      `CHK(resp_queue, ctrl_m[23:22])
      `CHK(mgmt_port_onehot, ((ctrl_m[18:16] <= 3'h2) ? 3'h1 << ctrl_m[18:16] : 3'h0))
      `CHK(mgmt_ethertype, ctrl_m[15:0])
      `CHK(hs_drive, drv_m[6:4])
      `CHK(ls_drive, drv_m[2:0])
      `CHK(addr_mismatch_err, err_m)
   endtask

   // Main sequence
   initial begin
      void'($urandom(32'h5a79));
      do_reset(1'b1);
      rd_chk(CTRL_OFFSET, ctrl_m);
      rd_chk(DRIVE_OFFSET, drv_m);
      chk_out;
      `CHK(sm_state, IBM_IDLE)
      // Every port code, random other fields; reserved bits must read zero
      for (i = 0; i < 8; i++) begin
         got = $urandom;
         got[18:16] = i[2:0];
         got[29] = 1'b0;
         wr(CTRL_OFFSET, got);
         rd_chk(CTRL_OFFSET, ctrl_m);
         wr(DRIVE_OFFSET, $urandom);
         rd_chk(DRIVE_OFFSET, drv_m);
         chk_out;
      end
      // Unmapped place: write ignored, read answers zero
      wr(12'h108, $urandom);
      rd_chk(12'h108, 32'h0);
      rd_chk(CTRL_OFFSET, ctrl_m);
      // Self-clearing state-machine reset
      wr(CTRL_OFFSET, ctrl_m | 32'h2000_0000);
      @(posedge clk);
      #1 `CHK(sm_state, IBM_INIT)
      @(posedge clk);
      #1 `CHK(sm_state, IBM_IDLE)
      rd_chk(CTRL_OFFSET, ctrl_m);
      // Frames under each filter setting; set wins over clear on the flag
      for (i = 0; i < 6; i++) begin
         wr(CTRL_OFFSET, fc[i]);
         host.send(fd[i], ft[i], acc);
         `CHK(acc, (ctrl_m[31] && ctrl_m[18:16] <= 3'h2 && (!ctrl_m[30] || fd[i])))
         if (ctrl_m[31] && ctrl_m[30] && !fd[i]) err_m = 1'b1;
         else if (ft[i]) err_m = 1'b0;
         `CHK(addr_mismatch_err, err_m)
      end
      // Second reset with the strap low: enable must follow the strap
      do_reset(1'b0);
      rd_chk(CTRL_OFFSET, ctrl_m);
      chk_out;
      wrap_up;
   end

   // Watchdog: the run needs well under a thousand cycles
   initial begin
      #100000;
      num_errors++;
      wrap_up;
   end
endmodule
`undef CHK
`default_nettype wire
